// ### logic/adc_seq_defines.svh
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH
// ----------------------------------------
// Register offsets (byte addresses).
// ----------------------------------------
`define ADC_OFF_MODE0 8'h00
`define ADC_OFF_CHAN 8'h04
`define ADC_OFF_PRIO 8'h08
`define ADC_OFF_MODE3 8'h0c
`define ADC_OFF_TRIG 8'h10
`define ADC_OFF_PRES 8'h20
`define ADC_RES_REGION 3'h2
// ----------------------------------------
// Field positions.
// ----------------------------------------
`define ADC_M0_START 0
`define ADC_M0_SCAN 1
`define ADC_M0_REPEAT 2
`define ADC_M0_ITM_LO 3
`define ADC_M0_BUSY 6
`define ADC_M0_DONE 7
`define ADC_PR_START 0
`define ADC_PR_CH_LO 1
`define ADC_PR_BUSY 4
`define ADC_PR_DONE 5
`define ADC_M3_SRST 0
`define ADC_TG_N_EN 0
`define ADC_TG_N_SRC 1
`define ADC_TG_P_EN 2
`define ADC_TG_P_SRC 3
// ----------------------------------------
// Interrupt timing codes and reset values.
// ----------------------------------------
`define ADC_ITM_EACH 2'h0
`define ADC_ITM_FOUR 2'h1
`define ADC_ITM_EIGHT 2'h2
`define ADC_ROT_FOUR_LAST 3'h3
`define ADC_ROT_EIGHT_LAST 3'h7
`define ADC_RST_CH 3'h0
`define ADC_RST_ITM 2'h0
`endif

// ### logic/adc_seq_pkg.sv
package adc_seq_pkg;
	// ----------------------------------------
	// Types shared by the sequencer.
	// ----------------------------------------
	typedef enum logic [1:0]
	{
		st_idle = 2'h0,
		st_norm = 2'h1,
		st_prio = 2'h3
	} seq_state_t;

	typedef struct packed
	{
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} wb_req_t;
endpackage

// ### logic/adc_conversion_sequencer.sv
`timescale 1ns/1ps
`include "adc_seq_defines.svh"
// Notes on behaviour
// - Normal start bit launches selected normal mode.
// - Priority start bit converts selected priority channel.
// - Priority conversion is always fixed single.
// - Source select picks pin edge or timer.
// - Hardware trigger needs its enable bit set.
// - Software start works with hardware triggering on.
// - Normal busy sets when normal conversion begins.
// - Priority busy sets when priority conversion begins.
// - Priority run leaves normal busy/done untouched.
// - Priority start suspends normal, then normal resumes.
// - Resume restarts the interrupted channel.
// - Clearing repeat ends run after current conversion.
// - Non fixed-repeat results go per channel.
// - Fixed single end: done, not busy, irq.
// - Scan single flags only after whole scan.
// - Fixed repeat keeps busy; done with irq.
// - Timing 00 interrupts each time, first register.
// - Timing 01 rotates four registers, irq fourth.
// - Timing 10 rotates eight registers, irq eighth.
// - Scan repeat flags per scan, busy stays.
// - Priority end: irq, done flag, priority result.
// - Reading a done flag clears it.
// - Priority start during priority is ignored.
// - Priority busy clears when priority completes.
module adc_conversion_sequencer #(
	parameter int RES_W = 10
)(
	// Clock, enable and reset
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	// Wishbone slave
	input wire adc_seq_pkg::wb_req_t wb_req,
	output logic [31:0] wb_dat_r,
	output logic wb_ack,
	// Trigger sources
	input wire logic external_trigger_pin,
	input wire logic timer6_match_event,
	input wire logic timer5_match_event,
	// Converter core
	output logic conv_start,
	output logic [2:0] conv_channel,
	input wire logic conv_done,
	input wire logic [RES_W-1:0] conv_data,
	// Completion events
	output logic normal_done_irq,
	output logic priority_done_irq
);
	import adc_seq_pkg::*;

	// ----------------------------------------
	// Configuration and status.
	// ----------------------------------------
	logic n_scan;
	logic n_repeat;
	logic [1:0] itm;
	logic [2:0] ch_sel;
	logic [2:0] prio_ch;
	logic normal_hw_trigger_en;
	logic normal_hw_source_sel;
	logic priority_hw_trigger_en;
	logic priority_hw_source_sel;
	seq_state_t state;
	logic n_run;
	logic run_rep;
	logic [2:0] cur_ch;
	logic [2:0] rot;
	logic n_busy;
	logic n_done;
	logic p_busy;
	logic p_done;
	logic [RES_W-1:0] res [8];
	logic [RES_W-1:0] prio_res;
	logic [2:0] trig_sync;
	logic trig_lvl;

	// ----------------------------------------
	// Bus decode.
	// ----------------------------------------
	logic bus_req;
	logic wr_take;
	logic rd_take;
	logic sw_norm;
	logic sw_prio;
	logic soft_rst;
	logic rd_n;
	logic rd_p;
	logic wr_mode0;
	logic wr_prio;
	logic n_scan_go;
	logic n_rep_go;
	logic [2:0] prio_ch_go;
	assign bus_req = wb_req.cyc & wb_req.stb;
	// Writes and read side effects happen at the edge the master samples ack.
	assign wr_take = bus_req & wb_ack & wb_req.we & wb_req.sel[0];
	assign rd_take = bus_req & wb_ack & ~wb_req.we;
	assign sw_norm = wr_take && wb_req.adr == `ADC_OFF_MODE0 && wb_req.dat[`ADC_M0_START];
	assign sw_prio = wr_take && wb_req.adr == `ADC_OFF_PRIO && wb_req.dat[`ADC_PR_START];
	assign soft_rst = wr_take && wb_req.adr == `ADC_OFF_MODE3 && wb_req.dat[`ADC_M3_SRST];
	assign rd_n = rd_take && wb_req.adr == `ADC_OFF_MODE0;
	assign rd_p = rd_take && wb_req.adr == `ADC_OFF_PRIO;
	// A start written together with its settings runs with the new settings.
	assign wr_mode0 = wr_take && wb_req.adr == `ADC_OFF_MODE0;
	assign wr_prio = wr_take && wb_req.adr == `ADC_OFF_PRIO;
	assign n_scan_go = wr_mode0 ? wb_req.dat[`ADC_M0_SCAN] : n_scan;
	assign n_rep_go = wr_mode0 ? wb_req.dat[`ADC_M0_REPEAT] : n_repeat;
	assign prio_ch_go = wr_prio ? wb_req.dat[`ADC_PR_CH_LO +: 3] : prio_ch;

	// ----------------------------------------
	// Trigger selection.
	// ----------------------------------------
	logic ext_fall;
	logic n_hw_evt;
	logic p_hw_evt;
	logic norm_req;
	logic prio_req;
	// The pin level only counts once two late stages agree, so a glitch cannot fire.
	assign ext_fall = trig_lvl && trig_sync[1] == trig_sync[2] && !trig_sync[2];
	assign n_hw_evt = normal_hw_trigger_en
		&& (normal_hw_source_sel ? timer6_match_event : ext_fall);
	assign p_hw_evt = priority_hw_trigger_en
		&& (priority_hw_source_sel ? timer5_match_event : ext_fall);
	assign norm_req = sw_norm | n_hw_evt;
	assign prio_req = sw_prio | p_hw_evt;

	// ----------------------------------------
	// Sequence decisions.
	// ----------------------------------------
	logic n_fin;
	logic p_fin;
	logic p_go;
	logic n_go;
	logic fixed_rep;
	logic seq_last;
	logic rot_last;
	logic n_event;
	logic n_stop;
	logic [2:0] next_ch;
	logic [2:0] next_rot;
	logic [2:0] dest;
	assign n_fin = state == st_norm && conv_done;
	assign p_fin = state == st_prio && conv_done;
	assign p_go = prio_req && state != st_prio;
	assign n_go = norm_req && state == st_idle;
	assign fixed_rep = run_rep && !n_scan;
	assign seq_last = !n_scan || cur_ch == ch_sel;
	assign rot_last = itm == `ADC_ITM_FOUR ? rot == `ADC_ROT_FOUR_LAST
		: itm == `ADC_ITM_EIGHT ? rot == `ADC_ROT_EIGHT_LAST : 1'b1;
	assign n_event = n_fin && (fixed_rep ? rot_last : seq_last);
	assign n_stop = n_fin && ((run_rep && !n_repeat) || (!run_rep && seq_last));
	assign next_ch = n_scan ? (seq_last ? 3'h0 : cur_ch + 3'h1) : ch_sel;
	assign next_rot = rot_last ? 3'h0 : rot + 3'h1;
	assign dest = fixed_rep ? (itm == `ADC_ITM_EACH ? 3'h0 : rot) : conv_channel;

	// ----------------------------------------
	// Pin synchroniser.
	// ----------------------------------------
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			trig_sync <= 3'h7;
			trig_lvl <= 1'b1;
		end
		else if (ce)
		begin
			trig_sync <= {trig_sync[1:0], external_trigger_pin};
			if (trig_sync[1] == trig_sync[2])
				trig_lvl <= trig_sync[2];
		end
	end

	// ----------------------------------------
	// Wishbone slave.
	// ----------------------------------------
	logic [31:0] rd_mux;
	always_comb
	begin
		rd_mux = 32'h0;
		if (wb_req.adr[7:5] == `ADC_RES_REGION && wb_req.adr[1:0] == 2'h0)
			rd_mux[RES_W-1:0] = res[wb_req.adr[4:2]];
		else
		begin
			unique case (wb_req.adr)
				`ADC_OFF_MODE0: rd_mux[7:0] = {n_done, n_busy, 1'b0, itm, n_repeat, n_scan, 1'b0};
				`ADC_OFF_CHAN: rd_mux[2:0] = ch_sel;
				`ADC_OFF_PRIO: rd_mux[5:0] = {p_done, p_busy, prio_ch, 1'b0};
				`ADC_OFF_TRIG: rd_mux[3:0] = {priority_hw_source_sel, priority_hw_trigger_en,
					normal_hw_source_sel, normal_hw_trigger_en};
				`ADC_OFF_PRES: rd_mux[RES_W-1:0] = prio_res;
				default: rd_mux = 32'h0;
			endcase
		end
	end

	// Every access is answered, an unmapped one with zero data.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wb_ack <= 1'b0;
			wb_dat_r <= 32'h0;
		end
		else if (ce)
		begin
			wb_ack <= bus_req & ~wb_ack;
			if (bus_req & ~wb_ack)
				wb_dat_r <= rd_mux;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			n_scan <= 1'b0;
			n_repeat <= 1'b0;
			itm <= `ADC_RST_ITM;
			ch_sel <= `ADC_RST_CH;
			prio_ch <= `ADC_RST_CH;
			normal_hw_trigger_en <= 1'b0;
			normal_hw_source_sel <= 1'b0;
			priority_hw_trigger_en <= 1'b0;
			priority_hw_source_sel <= 1'b0;
		end
		else if (ce && wr_take)
		begin
			unique case (wb_req.adr)
				`ADC_OFF_MODE0:
				begin
					n_scan <= wb_req.dat[`ADC_M0_SCAN];
					n_repeat <= wb_req.dat[`ADC_M0_REPEAT];
					itm <= wb_req.dat[`ADC_M0_ITM_LO +: 2];
				end
				`ADC_OFF_CHAN: ch_sel <= wb_req.dat[2:0];
				`ADC_OFF_PRIO: prio_ch <= wb_req.dat[`ADC_PR_CH_LO +: 3];
				`ADC_OFF_TRIG:
				begin
					normal_hw_trigger_en <= wb_req.dat[`ADC_TG_N_EN];
					normal_hw_source_sel <= wb_req.dat[`ADC_TG_N_SRC];
					priority_hw_trigger_en <= wb_req.dat[`ADC_TG_P_EN];
					priority_hw_source_sel <= wb_req.dat[`ADC_TG_P_SRC];
				end
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Conversion sequencer.
	// ----------------------------------------
	// A new start while the core is busy aborts its conversion; that is how
	// a priority request suspends a normal one without waiting for it.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state <= st_idle;
			conv_start <= 1'b0;
			conv_channel <= 3'h0;
			n_run <= 1'b0;
			run_rep <= 1'b0;
			cur_ch <= 3'h0;
			rot <= 3'h0;
		end
		else if (ce)
		begin
			conv_start <= 1'b0;
			if (soft_rst)
			begin
				state <= st_idle;
				n_run <= 1'b0;
			end
			else if (p_go)
			begin
				state <= st_prio;
				conv_start <= 1'b1;
				conv_channel <= prio_ch_go;
				if (n_go)
				begin
					n_run <= 1'b1;
					run_rep <= n_rep_go;
					cur_ch <= 3'h0;
					rot <= 3'h0;
				end
				else if (n_fin)
				begin
					n_run <= !n_stop;
					cur_ch <= next_ch;
					if (fixed_rep)
						rot <= next_rot;
				end
			end
			else
			begin
				unique case (state)
					st_idle:
					if (n_go)
					begin
						n_run <= 1'b1;
						run_rep <= n_rep_go;
						cur_ch <= 3'h0;
						rot <= 3'h0;
						state <= st_norm;
						conv_start <= 1'b1;
						conv_channel <= n_scan_go ? 3'h0 : ch_sel;
					end
					st_norm:
					if (n_fin)
					begin
						cur_ch <= next_ch;
						if (fixed_rep)
							rot <= next_rot;
						if (n_stop)
						begin
							n_run <= 1'b0;
							state <= st_idle;
						end
						else
						begin
							conv_start <= 1'b1;
							conv_channel <= next_ch;
						end
					end
					st_prio:
					if (conv_done)
					begin
						if (n_run)
						begin
							state <= st_norm;
							conv_start <= 1'b1;
							conv_channel <= n_scan ? cur_ch : ch_sel;
						end
						else
							state <= st_idle;
					end
					default: state <= st_idle;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Flags and completion events.
	// ----------------------------------------
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			n_busy <= 1'b0;
			n_done <= 1'b0;
			p_busy <= 1'b0;
			p_done <= 1'b0;
			normal_done_irq <= 1'b0;
			priority_done_irq <= 1'b0;
		end
		else if (ce)
		begin
			normal_done_irq <= n_event && !soft_rst;
			priority_done_irq <= p_fin && !soft_rst;
			if (soft_rst)
			begin
				n_busy <= 1'b0;
				n_done <= 1'b0;
				p_busy <= 1'b0;
				p_done <= 1'b0;
			end
			else
			begin
				if (n_go)
					n_busy <= 1'b1;
				else if (n_stop)
					n_busy <= 1'b0;
				// set wins over read clear
				// Only a flag that the read returned is cleared, so none is lost.
				n_done <= n_event | (n_done & ~(rd_n & wb_dat_r[`ADC_M0_DONE]));
				if (p_go)
					p_busy <= 1'b1;
				else if (p_fin)
					p_busy <= 1'b0;
				p_done <= p_fin | (p_done & ~(rd_p & wb_dat_r[`ADC_PR_DONE]));
			end
		end
	end

	// ----------------------------------------
	// Result registers.
	// ----------------------------------------
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			for (int i = 0; i < 8; i++)
				res[i] <= '0;
			prio_res <= '0;
		end
		else if (ce)
		begin
			if (n_fin)
				res[dest] <= conv_data;
			if (p_fin)
				prio_res <= conv_data;
		end
	end

	// ----------------------------------------
	// Checks.
	// ----------------------------------------
	// They assume ce stays high; a frozen cycle would stretch every delay.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n || !ce);

	sequence s_fixed_single_end;
		n_fin && !run_rep && !n_scan && !p_go && !soft_rst;
	endsequence
	sequence s_done_reported;
		n_done && !n_busy && normal_done_irq;
	endsequence

	property p_norm_start;
		sw_norm && state == st_idle && !prio_req && !soft_rst |=> n_busy && conv_start;
	endproperty
	a_norm_start: assert property (p_norm_start) else $error("normal start not taken");
	property p_prio_start;
		sw_prio && state != st_prio && !soft_rst
			|=> p_busy && conv_start && conv_channel == prio_ch;
	endproperty
	a_prio_start: assert property (p_prio_start) else $error("priority start wrong");
	property p_norm_kept;
		state == st_prio && !conv_done && !rd_n && !soft_rst
			|=> n_busy == $past(n_busy) && n_done == $past(n_done);
	endproperty
	a_norm_kept: assert property (p_norm_kept) else $error("normal flags disturbed");
	property p_prio_ignored;
		state == st_prio && prio_req && !conv_done && !soft_rst |=> !conv_start;
	endproperty
	a_prio_ignored: assert property (p_prio_ignored) else $error("nested priority ran");
	property p_resume;
		p_fin && n_run && n_scan && !soft_rst
			|=> conv_start && state == st_norm && conv_channel == $past(cur_ch);
	endproperty
	a_resume: assert property (p_resume) else $error("resume channel wrong");
	property p_fixed_single;
		s_fixed_single_end |=> s_done_reported;
	endproperty
	a_fixed_single: assert property (p_fixed_single) else $error("single end flags wrong");
	property p_repeat_busy;
		n_fin && run_rep && n_repeat && !soft_rst |=> n_busy ##1 (n_busy || $past(soft_rst));
	endproperty
	a_repeat_busy: assert property (p_repeat_busy) else $error("repeat busy dropped");
	property p_prio_end;
		p_fin && !soft_rst |=> priority_done_irq && p_done && !p_busy
			&& prio_res == $past(conv_data);
	endproperty
	a_prio_end: assert property (p_prio_end) else $error("priority end wrong");
	property p_read_clear;
		rd_n && wb_dat_r[`ADC_M0_DONE] && !n_event && !soft_rst |=> !n_done;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("done not cleared");
	property p_hw_drop;
		state == st_idle && !normal_hw_trigger_en && !sw_norm && !prio_req |=> !conv_start;
	endproperty
	a_hw_drop: assert property (p_hw_drop) else $error("disabled trigger started");
endmodule // adc_conversion_sequencer

// ### dv/conv_core_model.sv
`timescale 1ns/1ps
module conv_core_model (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Converter link
	input wire logic conv_start,
	input wire logic [2:0] conv_channel,
	input wire logic [3:0] lat,
	output logic conv_done,
	output logic [9:0] conv_data
);
	logic run;
	logic [3:0] cnt;
	logic [2:0] ch;
	logic [6:0] seq;
	// Data toggles outside the done cycle, so a stale sample never matches.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			run <= 1'b0;
			cnt <= 4'h0;
			ch <= 3'h0;
			seq <= 7'h0;
			conv_done <= 1'b0;
			conv_data <= 10'h0;
		end
		else
		begin
			conv_done <= 1'b0;
			conv_data <= ~conv_data;
			// A fresh start aborts the conversion in flight.
			if (conv_start)
			begin
				run <= 1'b1;
				cnt <= lat;
				ch <= conv_channel;
			end
			else if (run && cnt == 4'h0)
			begin
				run <= 1'b0;
				conv_done <= 1'b1;
				seq <= seq + 7'h1;
				conv_data <= {seq, ch};
			end
			else if (run)
				cnt <= cnt - 4'h1;
		end
	end
endmodule // conv_core_model

// ### dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import adc_seq_pkg::*;
	logic clk;
	logic arst_n;
	logic ce;
	wb_req_t req;
	logic [31:0] wb_dat_r;
	logic wb_ack;
	logic pin;
	logic t6;
	logic t5;
	logic conv_start;
	logic [2:0] conv_channel;
	logic conv_done;
	logic [9:0] conv_data;
	logic nirq;
	logic pirq;
	logic [3:0] lat;
	logic fix;
	logic [9:0] pdat;
	logic [9:0] log_q[$];
	logic [2:0] ch_q[$];
	logic [31:0] q;
	int starts;
	int nirqs;
	int pirqs;
	int bad_count;
	int compares;

	adc_conversion_sequencer u_adc_conversion_sequencer (
		.clk(clk),
		.arst_n(arst_n),
		.ce(ce),
		.wb_req(req),
		.wb_dat_r(wb_dat_r),
		.wb_ack(wb_ack),
		.external_trigger_pin(pin),
		.timer6_match_event(t6),
		.timer5_match_event(t5),
		.conv_start(conv_start),
		.conv_channel(conv_channel),
		.conv_done(conv_done),
		.conv_data(conv_data),
		.normal_done_irq(nirq),
		.priority_done_irq(pirq)
	);

	conv_core_model u_conv_core_model (
		.clk(clk),
		.arst_n(arst_n),
		.conv_start(conv_start),
		.conv_channel(conv_channel),
		.lat(lat),
		.conv_done(conv_done),
		.conv_data(conv_data)
	);

	initial
	begin
		clk = 1'b0;
		forever
			#50 clk = ~clk;
	end

	// Stalls are redrawn after every result; fix holds them long.
	always @(posedge clk)
	begin
		if (conv_start === 1'b1)
		begin
			starts++;
			ch_q.push_back(conv_channel);
		end
		if (arst_n !== 1'b1)
			lat <= 4'hf;
		else if (conv_done === 1'b1)
		begin
			log_q.push_back(conv_data);
			if (ch_q[$] === 3'h7)
				pdat = conv_data;
			lat <= fix ? 4'hf : 4'($urandom_range(9));
		end
		nirqs += int'(nirq === 1'b1);
		pirqs += int'(pirq === 1'b1);
	end

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e)
		begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		n = 0;
		req <= '{1'b1, 1'b1, w, a, 4'hf, d};
		@(posedge clk);
		while (wb_ack !== 1'b1 && n < 50)
		begin
			@(posedge clk);
			n++;
		end
		if (wb_ack !== 1'b1)
			bad_count++;
		r = wb_dat_r;
		req <= '0;
		@(posedge clk);
	endtask

	task automatic wait_c(ref int c, input int k);
		repeat (3000)
			if (c < k)
				@(posedge clk);
		if (c < k)
			bad_count++;
	endtask

	// The last result written to each slot of a rotation.
	function automatic logic [9:0] last_in(int l, int m, int j);
		logic [9:0] v;
		v = 'x;
		for (int i = l; i < log_q.size(); i++)
			if ((i - l) % m == j)
				v = log_q[i];
		return v;
	endfunction

	task automatic summarize();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		#2000000;
		bad_count++;
		summarize();
	end

	initial
	begin
		int c;
		int k;
		int s;
		int l;
		int m;
		void'($urandom(30));
		ce = 1'b1;
		arst_n = 1'b0;
		req = '0;
		pin = 1'b1;
		t6 = 1'b0;
		t5 = 1'b0;
		fix = 1'b1;
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		wb(1, 8'h7c, 32'hff, q);
		wb(0, 8'h7c, 0, q);
		chk("unmapped", q, 0);
		c = $urandom_range(7);
		k = nirqs;
		s = starts;
		wb(1, 8'h04, c, q);
		wb(1, 8'h00, 32'h1, q);
		wb(0, 8'h00, 0, q);
		chk("busy", q[7:6], 2'h1);
		wait_c(nirqs, k + 1);
		fix = 1'b0;
		chk("chan", conv_channel, c);
		chk("one conv", starts - s, 1);
		wb(0, 8'h00, 0, q);
		chk("flags", q[7:6], 2'h2);
		wb(0, 8'h00, 0, q);
		chk("clear", q[7], 0);
		wb(0, 8'h40 + 8'(4 * c), 0, q);
		chk("res", q, log_q[$]);
		c = $urandom_range(1, 7);
		k = nirqs;
		s = starts;
		wb(1, 8'h04, c, q);
		wb(1, 8'h00, 32'h3, q);
		wait_c(nirqs, k + 1);
		chk("scan count", starts - s, c + 1);
		repeat (20) @(posedge clk);
		chk("scan irqs", nirqs - k, 1);
		wb(0, 8'h00, 0, q);
		chk("scan flags", q[7:6], 2'h2);
		for (int i = 0; i <= c; i++)
		begin
			wb(0, 8'h40 + 8'(4 * i), 0, q);
			chk("scan res", q, log_q[log_q.size() - 1 - c + i]);
		end
		for (int t = 0; t < 3; t++)
		begin
			m = (t == 0) ? 1 : 4 * t;
			l = log_q.size();
			k = nirqs;
			wb(1, 8'h00, 32'h5 | (t << 3), q);
			wait_c(nirqs, k + 2);
			wb(0, 8'h00, 0, q);
			chk("rep busy", q[6], 1);
			wb(1, 8'h00, t << 3, q);
			repeat (40)
			begin
				wb(0, 8'h00, 0, q);
				if (q[6] === 1'b0)
					break;
			end
			chk("stop busy", q[6], 0);
			s = starts;
			repeat (30) @(posedge clk);
			chk("stopped", starts - s, 0);
			chk("rep irqs", nirqs - k, (log_q.size() - l) / m);
			for (int j = 0; j < m; j++)
			begin
				wb(0, 8'h40 + 8'(4 * j), 0, q);
				chk("rep res", q, last_in(l, m, j));
			end
		end
		fix = 1'b1;
		wb(1, 8'h04, 3, q);
		wb(1, 8'h00, 32'h7, q);
		repeat (500)
			if (!(conv_start === 1'b1 && conv_channel === 3'h2))
				@(posedge clk);
		if (!(conv_start === 1'b1 && conv_channel === 3'h2))
			bad_count++;
		// Let the start counter take this start before it is read.
		@(posedge clk);
		s = starts;
		k = pirqs;
		// no normal start while the priority run is on.
		wb(1, 8'h08, 32'hf, q);
		wb(0, 8'h00, 0, q);
		chk("kept", q[7:6], 2'h1);
		wb(1, 8'h08, 32'hb, q);
		wb(0, 8'h08, 0, q);
		chk("prio busy", q[4], 1);
		chk("prio once", starts - s, 1);
		chk("prio chan", ch_q[$], 7);
		wait_c(pirqs, k + 1);
		@(posedge clk);
		chk("resume", ch_q[$], 2);
		wb(0, 8'h08, 0, q);
		chk("prio flags", q[5:4], 2'h2);
		wb(0, 8'h08, 0, q);
		chk("prio clear", q[5], 0);
		wb(0, 8'h20, 0, q);
		chk("prio res", q, pdat);
		// the running scan repeat sequence is stopped by soft reset.
		wb(1, 8'h0c, 1, q);
		fix = 1'b0;
		wb(1, 8'h04, 6, q);
		// Back to fixed single mode, so each trigger gives one conversion.
		wb(1, 8'h00, 0, q);
		wb(1, 8'h10, 32'h2, q);
		s = starts;
		t6 <= 1'b1;
		@(posedge clk);
		t6 <= 1'b0;
		wb(1, 8'h10, 32'h3, q);
		repeat (5) @(posedge clk);
		chk("dropped", starts - s, 0);
		k = nirqs;
		t6 <= 1'b1;
		@(posedge clk);
		t6 <= 1'b0;
		wait_c(nirqs, k + 1);
		chk("timer6", starts - s, 1);
		wb(1, 8'h00, 32'h1, q);
		wait_c(nirqs, k + 2);
		chk("sw start", starts - s, 2);
		wb(1, 8'h10, 32'h1, q);
		pin <= 1'b0;
		repeat (3) @(posedge clk);
		pin <= 1'b1;
		wait_c(nirqs, k + 3);
		chk("pin", starts - s, 3);
		wb(1, 8'h10, 32'hc, q);
		wb(1, 8'h08, 32'ha, q);
		k = pirqs;
		t5 <= 1'b1;
		@(posedge clk);
		t5 <= 1'b0;
		wait_c(pirqs, k + 1);
		repeat (10) @(posedge clk);
		chk("timer5 chan", ch_q[$], 5);
		chk("timer5 once", starts - s, 4);
		summarize();
	end
endmodule // tb_top
